// >>> core/axis_motion_status_word.sv
// Two-axis motion status word bank with AXI4-Lite register access
//
// Design decision made here: the AXI4-Lite interface to the registers.
module axis_motion_status_word
  import motion_status_pkg::*;
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [9:0]              s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // AXI4-Lite write response
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [9:0]              s_axi_araddr,
  // AXI4-Lite read data
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // Command from the unit's interpreter (same clock)
  input  wire logic                    cmd_valid,
  input  motion_status_pkg::cmd_t      cmd_code,
  input  motion_status_pkg::axis_t     cmd_axis,
  input  wire logic [15:0]             scale_coef,
  // Per-axis motion events, bit 0 = X, bit 1 = Y (same clock)
  input  wire logic [1:0]              pos_negative,
  input  wire logic [1:0]              origin_valid,
  input  wire logic [1:0]              moving,
  input  wire logic [1:0]              move_complete,
  input  wire logic [1:0]              decel_done,
  input  wire logic [1:0]              intr_done,
  input  wire logic [1:0]              step_done,
  input  wire logic [1:0]              home_done,
  input  wire logic [1:0]              dwell_start,
  input  wire logic [1:0]              dwell_end,
  input  wire logic [1:0]              sys_error,
  // External interrupt pins, asynchronous
  input  wire logic [1:0]              ext_interrupt_pin,
  // Data store events (same clock)
  input  wire logic                    wipe_actions,
  input  wire logic                    wipe_params,
  input  wire logic                    action_stored,
  input  wire logic                    param_stored,
  input  wire logic                    params_in_range,
  // Interrupt
  output logic                         irq
);

  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_ADDR = 2'b01,
    WR_RESP = 2'b11,
    WR_DATA = 2'b10
  } wr_state_t;

  typedef struct packed {
    logic [15:0] xs;
    logic [15:0] ys;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    logic [1:0]  ext_s1;
    logic [1:0]  ext_s2;
    logic [1:0]  ext_q;
    wr_state_t   wst;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [15:0] x_next;
  logic [15:0] y_next;
  logic [1:0]  hit;
  logic [1:0]  ext_rise;

  // Byte address to word index
  function automatic logic [7:0] word_idx(input logic [9:0] a);
    word_idx = a[9:2];
  endfunction

  // ==========================================================
  // Axis routing
  // ==========================================================
  // prefix picks the word
  assign hit[0] = cmd_valid && cmd_axis[0];
  assign hit[1] = cmd_valid && cmd_axis[1];
  // External interrupt edge after the two synchroniser stages
  assign ext_rise = st_reg.ext_s2 & ~st_reg.ext_q;

  axis_flag_engine u_x (
    .cur             (st_reg.xs),
    .hit             (hit[0]),
    .cmd             (cmd_code),
    .scale_coef      (scale_coef),
    .pos_negative    (pos_negative[0]),
    .origin_valid    (origin_valid[0]),
    .moving          (moving[0]),
    .ext_interrupt   (ext_rise[0]),
    .move_complete   (move_complete[0]),
    .decel_done      (decel_done[0]),
    .intr_done       (intr_done[0]),
    .step_done       (step_done[0]),
    .home_done       (home_done[0]),
    .dwell_start     (dwell_start[0]),
    .dwell_end       (dwell_end[0]),
    .wipe_actions    (wipe_actions),
    .wipe_params     (wipe_params),
    .action_stored   (action_stored),
    .param_stored    (param_stored),
    .params_in_range (params_in_range),
    .sys_error       (sys_error[0]),
    .nxt             (x_next)
  );

  axis_flag_engine u_y (
    .cur             (st_reg.ys),
    .hit             (hit[1]),
    .cmd             (cmd_code),
    .scale_coef      (scale_coef),
    .pos_negative    (pos_negative[1]),
    .origin_valid    (origin_valid[1]),
    .moving          (moving[1]),
    .ext_interrupt   (ext_rise[1]),
    .move_complete   (move_complete[1]),
    .decel_done      (decel_done[1]),
    .intr_done       (intr_done[1]),
    .step_done       (step_done[1]),
    .home_done       (home_done[1]),
    .dwell_start     (dwell_start[1]),
    .dwell_end       (dwell_end[1]),
    .wipe_actions    (wipe_actions),
    .wipe_params     (wipe_params),
    .action_stored   (action_stored),
    .param_stored    (param_stored),
    .params_in_range (params_in_range),
    .sys_error       (sys_error[1]),
    .nxt             (y_next)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic [1:0] clr;
    logic [1:0] mset;
    logic       wdo;
    clr  = 2'b00;
    mset = 2'b00;
    wdo  = 1'b0;
    st_next = st_reg;

    // Two-flop synchronisers; only stage two feeds logic
    st_next.ext_s1 = ext_interrupt_pin;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.ext_q  = st_reg.ext_s2;

    st_next.xs = x_next;
    st_next.ys = y_next;

    // Write channel: address and data in either order
    case (st_reg.wst)
      WR_IDLE: begin
        st_next.awready = 1'b1;
        st_next.wready  = 1'b1;
        if (s_axi_awvalid && st_reg.awready) begin
          st_next.waddr   = word_idx(s_axi_awaddr);
          st_next.awready = 1'b0;
        end
        if (s_axi_wvalid && st_reg.wready) begin
          st_next.wdata  = s_axi_wdata;
          st_next.wstrb  = s_axi_wstrb;
          st_next.wready = 1'b0;
        end
        if (s_axi_awvalid && st_reg.awready &&
            s_axi_wvalid && st_reg.wready) begin
          st_next.wst = WR_RESP;
          wdo = 1'b1;
        end else if (s_axi_awvalid && st_reg.awready) begin
          st_next.wst = WR_ADDR;
        end else if (s_axi_wvalid && st_reg.wready) begin
          st_next.wst = WR_DATA;
        end
      end
      WR_ADDR: begin
        if (s_axi_wvalid && st_reg.wready) begin
          st_next.wdata  = s_axi_wdata;
          st_next.wstrb  = s_axi_wstrb;
          st_next.wready = 1'b0;
          st_next.wst    = WR_RESP;
          wdo = 1'b1;
        end
      end
      WR_DATA: begin
        if (s_axi_awvalid && st_reg.awready) begin
          st_next.waddr   = word_idx(s_axi_awaddr);
          st_next.awready = 1'b0;
          st_next.wst     = WR_RESP;
          wdo = 1'b1;
        end
      end
      WR_RESP: begin
        if (st_reg.bvalid && s_axi_bready) begin
          st_next.bvalid  = 1'b0;
          st_next.awready = 1'b1;
          st_next.wready  = 1'b1;
          st_next.wst     = WR_IDLE;
        end
      end
      default: st_next.wst = WR_IDLE;
    endcase

    // Register write effect, decided once both halves are held
    if (wdo) begin
      logic [7:0]  a;
      logic [31:0] d;
      logic [3:0]  s;
      a = st_next.waddr;
      d = st_next.wdata;
      s = st_next.wstrb;
      st_next.bvalid = 1'b1;
      st_next.bresp  = 2'b00;
      case (a)
        // writes to status words are refused
        X_STATUS_IDX, Y_STATUS_IDX: st_next.bresp = 2'b10;
        IRQ_STATUS_IDX: if (s[0]) clr = d[1:0];
        IRQ_MASK_IDX:   if (s[0]) begin
          mset = 2'b11;
          st_next.irq_mask = d[1:0];
        end
        SIGN_CTRL_IDX:  ;
        default: st_next.bresp = 2'b10;
      endcase
    end

    // Sticky change flags; a new event wins over the clear
    st_next.irq_st = (st_reg.irq_st & ~clr) |
                     {(y_next != st_reg.ys), (x_next != st_reg.xs)};
    st_next.irq    = |(st_next.irq_st & st_next.irq_mask);

    // Read channel: one read at a time
    if (st_reg.rvalid) begin
      if (s_axi_rready) begin
        st_next.rvalid  = 1'b0;
        st_next.arready = 1'b1;
      end
    end else if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = 2'b00;
      case (word_idx(s_axi_araddr))
        X_STATUS_IDX:   st_next.rdata = {16'h0000, st_reg.xs};
        Y_STATUS_IDX:   st_next.rdata = {16'h0000, st_reg.ys};
        IRQ_STATUS_IDX: st_next.rdata = {30'h0, st_reg.irq_st};
        IRQ_MASK_IDX:   st_next.rdata = {30'h0, st_reg.irq_mask};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = 2'b10;
        end
      endcase
    end else begin
      st_next.arready = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= '0;
      st_reg.xs       <= STATUS_RESET;
      st_reg.ys       <= STATUS_RESET;
      st_reg.wst      <= WR_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign irq           = st_reg.irq;

endmodule

// >>> core/motion_status_pkg.sv
// Package: register map, status bit positions, reset values and codes
package motion_status_pkg;

  // ==========================================================
  // Register map (printed word offsets are indices; byte = 4x)
  // ==========================================================
  localparam logic [7:0] X_STATUS_IDX   = 8'h03;
  localparam logic [7:0] Y_STATUS_IDX   = 8'h0a;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
  localparam logic [7:0] IRQ_MASK_IDX   = 8'h21;
  localparam logic [7:0] SIGN_CTRL_IDX  = 8'h22;

  // ==========================================================
  // Status word bit positions
  // ==========================================================
  localparam int BIT_NEG     = 0;
  localparam int BIT_EMG     = 1;
  localparam int BIT_PAUSE   = 2;
  localparam int BIT_STOP    = 3;
  localparam int BIT_POS     = 4;
  localparam int BIT_JOG     = 5;
  localparam int BIT_STEP    = 6;
  localparam int BIT_HOME    = 7;
  localparam int BIT_DONE    = 8;
  localparam int BIT_DWELL   = 9;
  localparam int BIT_SCALE   = 10;
  localparam int BIT_HOFS    = 11;
  localparam int BIT_ACTCLR  = 12;
  localparam int BIT_PARCLR  = 13;
  localparam int BIT_ORGSET  = 14;
  localparam int BIT_PAROK   = 15;

  // Reset value: only the stop flag starts high
  localparam logic [15:0] STATUS_RESET = 16'h0008;

  // Bits that a system error leaves alone (scale, offset, clears, par ok)
  // The emergency bit is also kept: it may read one or stay unchanged.
  localparam logic [15:0] SYSERR_KEEP  = 16'hbc02;

  // Interrupt status bits: X word changed, Y word changed
  localparam int IRQ_X = 0;
  localparam int IRQ_Y = 1;

  // Coefficient 1.0 in the 8.8 fixed point speed scaling input
  localparam logic [15:0] SCALE_UNITY  = 16'h0100;

  // ==========================================================
  // Command and event codes
  // ==========================================================
  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_LAUNCH    = 4'h1,
    CMD_DECEL     = 4'h2,
    CMD_JOG       = 4'h3,
    CMD_STEP      = 4'h4,
    CMD_HOME      = 4'h5,
    CMD_SCALE     = 4'h6,
    CMD_PAUSE     = 4'h7,
    CMD_RESUME    = 4'h8,
    CMD_EMERGENCY = 4'h9,
    CMD_FAULT_CLR = 4'ha,
    CMD_SET_POS   = 4'hb,
    CMD_HOFS_ON   = 4'hc,
    CMD_HOFS_OFF  = 4'hd
  } cmd_t;

  // Axis selector: X, Y, or interpolation (both)
  typedef enum logic [1:0] {
    AXIS_X    = 2'h1,
    AXIS_Y    = 2'h2,
    AXIS_BOTH = 2'h3
  } axis_t;

endpackage

// >>> core/axis_flag_engine.sv
// Per-axis flag update logic for one motion status word
module axis_flag_engine
  import motion_status_pkg::*;
(
  // Current word
  input  wire logic [15:0]       cur,
  // Command and events for this axis
  input  wire logic              hit,
  input  motion_status_pkg::cmd_t cmd,
  input  wire logic [15:0]       scale_coef,
  input  wire logic              pos_negative,
  input  wire logic              origin_valid,
  input  wire logic              moving,
  input  wire logic              ext_interrupt,
  input  wire logic              move_complete,
  input  wire logic              decel_done,
  input  wire logic              intr_done,
  input  wire logic              step_done,
  input  wire logic              home_done,
  input  wire logic              dwell_start,
  input  wire logic              dwell_end,
  input  wire logic              wipe_actions,
  input  wire logic              wipe_params,
  input  wire logic              action_stored,
  input  wire logic              param_stored,
  input  wire logic              params_in_range,
  input  wire logic              sys_error,
  // Next word
  output logic [15:0]            nxt
);

  function automatic logic is_cmd(input logic h, input cmd_t c,
                                  input cmd_t want);
    is_cmd = h && (c == want);
  endfunction

  // Flag update; later assignments carry priority
  always_comb begin
    nxt = cur;
    nxt[BIT_NEG] = pos_negative && origin_valid;
    if (is_cmd(hit, cmd, CMD_FAULT_CLR)) nxt[BIT_EMG] = 1'b0;
    if (is_cmd(hit, cmd, CMD_EMERGENCY) || ext_interrupt)
      nxt[BIT_EMG] = 1'b1;
    if (is_cmd(hit, cmd, CMD_PAUSE)) nxt[BIT_PAUSE] = 1'b1;
    if (is_cmd(hit, cmd, CMD_RESUME) || is_cmd(hit, cmd, CMD_DECEL) ||
        is_cmd(hit, cmd, CMD_EMERGENCY) || ext_interrupt)
      nxt[BIT_PAUSE] = 1'b0;
    nxt[BIT_STOP] = !moving;
    if (is_cmd(hit, cmd, CMD_LAUNCH) || is_cmd(hit, cmd, CMD_JOG) ||
        is_cmd(hit, cmd, CMD_STEP) || is_cmd(hit, cmd, CMD_HOME))
      nxt[BIT_STOP] = 1'b0;
    if (move_complete || decel_done || intr_done) nxt[BIT_POS] = 1'b0;
    if (is_cmd(hit, cmd, CMD_LAUNCH)) nxt[BIT_POS] = 1'b1;
    if (decel_done || intr_done) nxt[BIT_JOG] = 1'b0;
    if (is_cmd(hit, cmd, CMD_JOG)) nxt[BIT_JOG] = 1'b1;
    if (step_done) nxt[BIT_STEP] = 1'b0;
    if (is_cmd(hit, cmd, CMD_STEP)) nxt[BIT_STEP] = 1'b1;
    if (home_done || decel_done) nxt[BIT_HOME] = 1'b0;
    if (is_cmd(hit, cmd, CMD_HOME)) nxt[BIT_HOME] = 1'b1;
    if (dwell_start) nxt[BIT_DWELL] = 1'b1;
    if (dwell_end || is_cmd(hit, cmd, CMD_EMERGENCY))
      nxt[BIT_DWELL] = 1'b0;
    if (dwell_end && cur[BIT_DWELL]) nxt[BIT_DONE] = 1'b1;
    if (is_cmd(hit, cmd, CMD_LAUNCH)) nxt[BIT_DONE] = 1'b0;
    if (is_cmd(hit, cmd, CMD_SCALE))
      nxt[BIT_SCALE] = (scale_coef != SCALE_UNITY);
    if (is_cmd(hit, cmd, CMD_HOFS_ON))  nxt[BIT_HOFS] = 1'b1;
    if (is_cmd(hit, cmd, CMD_HOFS_OFF)) nxt[BIT_HOFS] = 1'b0;
    // actions wiped; a new action wins
    if (wipe_actions)  nxt[BIT_ACTCLR] = 1'b1;
    if (action_stored) nxt[BIT_ACTCLR] = 1'b0;
    if (wipe_params)  nxt[BIT_PARCLR] = 1'b1;
    if (param_stored) nxt[BIT_PARCLR] = 1'b0;
    if (home_done || is_cmd(hit, cmd, CMD_SET_POS))
      nxt[BIT_ORGSET] = 1'b1;
    nxt[BIT_PAROK] = params_in_range;
    // System error forces defaults on affected bits
    if (sys_error)
      nxt = (nxt & SYSERR_KEEP) | (STATUS_RESET & ~SYSERR_KEEP);
  end

endmodule

// >>> verification/status_checker.sv
// Checker: bus handshake and register map properties of the status bank
module status_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [9:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Read side
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [9:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Transfer steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================================
  // Properties
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_b_answer: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write answer late");
  a_r_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  // Status words refuse writes but read cleanly in the low half
  a_ro_refuse: assert property (
    wr_taken ##0 (s_axi_awaddr inside {10'h00c, 10'h028})
    |=> s_axi_bresp == 2'h2) else $error("status write not refused");
  a_map_read: assert property (
    rd_taken ##0 (s_axi_araddr inside {10'h00c, 10'h028})
    |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:16] == 16'h0000)
    else $error("status read malformed");
  a_spare_read: assert property (
    rd_taken ##0 (s_axi_araddr == 10'h088)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("spare read");
endmodule

bind axis_motion_status_word status_checker i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp
);

// >>> verification/host_model.sv
// Host model: register bus master that reads and writes the status bank
module host_model (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic             awv,
  input  wire logic        awr,
  output logic [9:0]       awa,
  output logic             wv,
  input  wire logic        wrd,
  output logic [31:0]      wd,
  output logic [3:0]       ws,
  input  wire logic        bv,
  output logic             br,
  // Read channels
  output logic             arv,
  input  wire logic        arr,
  output logic [9:0]       ara,
  input  wire logic        rv,
  output logic             rr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial {awv, wv, br, arv, rr, awa, ara, wd, ws} = '0;
  // Offer address and data together; each drops after its own ready
  task automatic put(input logic [9:0] a, input logic [31:0] d);
    logic ap;
    logic dp;
    @(posedge aclk);
    {awv, wv, br, awa, wd, ws} <= {3'h7, a, d, 4'hf};
    ap = 1'b1;
    dp = 1'b1;
    while (ap || dp) begin
      @(negedge aclk);
      ap = ap && !awr;
      dp = dp && !wrd;
      @(posedge aclk);
      awv <= ap;
      wv  <= dp;
    end
    // Released lines show a changed value, not the stale one
    awa <= ~a;
    wd  <= ~d;
    do @(negedge aclk); while (!bv);
    @(posedge aclk);
    br <= 1'b0;
  endtask
  // Read: hold the request until taken, then wait for the answer
  task automatic get(input logic [9:0] a);
    @(posedge aclk);
    {arv, rr, ara} <= {2'h3, a};
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    {arv, ara} <= {1'b0, ~a};
    do @(negedge aclk); while (!rv);
    @(posedge aclk);
    rr <= 1'b0;
  endtask
endmodule

// >>> verification/tb_top.sv
// Testbench: drives commands and events, checks status words over the bus
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import motion_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        cmd_valid = 1'b0;
  cmd_t        cmd_code = CMD_NONE;
  axis_t       cmd_axis = AXIS_X;
  logic [15:0] coef = 16'h0100;
  logic [1:0]  neg = 2'h0, home_search_cmd = 2'h0, mov = 2'h0, pin = 2'h0;
  logic        par = 1'b0;
  logic [1:0]  ev [12] = '{default: 2'h0};
  logic        awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, irq;
  logic [9:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, bexp;
  logic [33:0] rexp;
  logic [33:0] rq [$];
  logic [1:0]  bq [$];
  logic [15:0] ex = 16'h0008, ey = 16'h0008;
  int          bad_count = 0, cmp_count = 0, cyc = 0, seed = 43618;
  // ==========================================================
  // Device and host
  axis_motion_status_word i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_axis(cmd_axis), .scale_coef(coef),
    .pos_negative(neg), .origin_valid(home_search_cmd), .moving(mov),
    .move_complete(ev[0]), .decel_done(ev[1]), .intr_done(ev[2]),
    .step_done(ev[3]), .home_done(ev[4]), .dwell_start(ev[5]),
    .dwell_end(ev[6]), .sys_error(ev[7]), .ext_interrupt_pin(pin),
    .wipe_actions(ev[8][0]), .wipe_params(ev[9][0]),
    .action_stored(ev[10][0]), .param_stored(ev[11][0]),
    .params_in_range(par), .irq(irq));
  host_model i_host (.aclk(aclk), .awv(awv), .awr(awr), .awa(awa), .wv(wv),
    .wrd(wrd), .wd(wd), .ws(ws), .bv(bv), .br(br), .arv(arv), .arr(arr),
    .ara(ara), .rv(rv), .rr(rr));
  // ==========================================================
  // Clock, hang guard and answer checking
  always #50 aclk = ~aclk;
  // The tests need a few hundred cycles; this limit is far above that
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Each answer meets the oldest note just before its handshake edge
  always @(negedge aclk) begin
    if (rv && rr) begin
      rexp = rq.pop_front();
      `CHK({rresp, rdat}, rexp)
    end
    if (bv && br) begin
      bexp = bq.pop_front();
      `CHK(bresp, bexp)
    end
  end
  // ==========================================================
  // Tasks
  task automatic rx(input logic [9:0] a, input logic [33:0] e);
    rq.push_back(e);
    i_host.get(a);
  endtask
  task automatic wx(input logic [9:0] a, input logic [31:0] d);
    bq.push_back(2'h0);
    i_host.put(a, d);
  endtask
  task automatic chk();
    rx(10'h00c, {18'h0, ex});
    rx(10'h028, {18'h0, ey});
  endtask
  task automatic cmd(input cmd_t c, input axis_t x);
    @(posedge aclk);
    {cmd_valid, cmd_code, cmd_axis} <= {1'b1, c, x};
    @(posedge aclk);
    cmd_valid <= 1'b0;
  endtask
  task automatic pulse(input int k, input logic [1:0] m);
    @(posedge aclk);
    ev[k] <= m;
    @(posedge aclk);
    ev[k] <= 2'h0;
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    `CHK(irq, e)
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk();
    rx(10'h088, {2'h2, 32'h0});
    rx(10'h3fc, {2'h2, 32'h0});
    bq.push_back(2'h2);
    i_host.put(10'h00c, 32'hffff_ffff);
    bq.push_back(2'h2);
    i_host.put(10'h028, 32'h0000_0000);
    chk();
    $display("test map done");
    // Move, dwell, restart, pause and decelerate
    mov <= 2'h1;
    cmd(CMD_LAUNCH, AXIS_X);
    ex = 16'h0010;
    chk();
    pulse(0, 2'h1);
    pulse(5, 2'h1);
    ex = 16'h0200;
    chk();
    pulse(6, 2'h1);
    mov <= 2'h0;
    ex = 16'h0108;
    chk();
    mov <= 2'h1;
    cmd(CMD_LAUNCH, AXIS_X);
    cmd(CMD_PAUSE, AXIS_X);
    ex = 16'h0014;
    chk();
    cmd(CMD_DECEL, AXIS_X);
    pulse(1, 2'h1);
    mov <= 2'h0;
    ex = 16'h0008;
    chk();
    // Halt during dwell, fault clear, resume, external interrupt
    mov <= 2'h1;
    cmd(CMD_LAUNCH, AXIS_X);
    pulse(0, 2'h1);
    pulse(5, 2'h1);
    cmd(CMD_PAUSE, AXIS_X);
    cmd(CMD_EMERGENCY, AXIS_X);
    ex = 16'h0002;
    chk();
    cmd(CMD_FAULT_CLR, AXIS_X);
    mov <= 2'h0;
    cmd(CMD_PAUSE, AXIS_X);
    cmd(CMD_RESUME, AXIS_X);
    ex = 16'h0008;
    chk();
    cmd(CMD_PAUSE, AXIS_X);
    pin <= 2'h1;
    repeat (6) @(posedge aclk);
    pin <= 2'h0;
    ex = 16'h000a;
    chk();
    cmd(CMD_FAULT_CLR, AXIS_X);
    $display("test halts done");
    // Axis selection, jog, step and home search
    mov <= 2'h3;
    cmd(CMD_JOG, AXIS_BOTH);
    {ex, ey} = {16'h0020, 16'h0020};
    chk();
    pulse(2, 2'h1);
    pulse(1, 2'h2);
    cmd(CMD_STEP, AXIS_Y);
    {ex, ey} = {16'h0000, 16'h0040};
    chk();
    pulse(3, 2'h2);
    cmd(CMD_HOME, AXIS_X);
    {ex, ey} = {16'h0080, 16'h0000};
    chk();
    pulse(4, 2'h1);
    {mov, home_search_cmd, neg} <= {2'h0, 2'h1, 2'h3};
    {ex, ey} = {16'h4009, 16'h0008};
    chk();
    $display("test motion done");
    // Settings, wipes and parameter range
    repeat (3) begin
      coef <= 16'h0101 + 16'($unsigned($random(seed)) % 16'hfe00);
      cmd(CMD_SCALE, AXIS_X);
      ex = 16'h4409;
      chk();
      coef <= 16'h0100;
      cmd(CMD_SCALE, AXIS_X);
      ex = 16'h4009;
      chk();
    end
    cmd(CMD_HOFS_ON, AXIS_X);
    cmd(CMD_SET_POS, AXIS_Y);
    pulse(8, 2'h1);
    pulse(9, 2'h1);
    {ex, ey} = {16'h7809, 16'h7008};
    chk();
    pulse(10, 2'h1);
    pulse(11, 2'h1);
    par <= 1'b1;
    {ex, ey} = {16'hc809, 16'hc008};
    chk();
    // System error mid-move keeps only the persistent flags
    coef <= 16'h0180;
    cmd(CMD_SCALE, AXIS_X);
    mov <= 2'h1;
    cmd(CMD_LAUNCH, AXIS_X);
    {ev[7], mov, neg} <= {2'h1, 2'h0, 2'h0};
    @(posedge aclk);
    ev[7] <= 2'h0;
    ex = 16'h8c08;
    chk();
    $display("test error done");
    // Interrupt: change event, mask, clear
    wx(10'h084, 32'h1);
    wx(10'h080, 32'h3);
    irq_is(1'b0);
    cmd(CMD_HOFS_OFF, AXIS_X);
    irq_is(1'b1);
    rx(10'h080, {2'h0, 32'h1});
    wx(10'h080, 32'h1);
    irq_is(1'b0);
    wx(10'h084, 32'h0);
    cmd(CMD_HOFS_ON, AXIS_Y);
    irq_is(1'b0);
    rx(10'h080, {2'h0, 32'h2});
    {ex, ey} = {16'h8408, 16'hc808};
    chk();
    $display("test irq done");
    give_verdict();
  end
endmodule
